//--- src/iso_rx_defines.svh
// Register offsets, field positions, reset values and codes of the receive context match block.
`ifndef ISO_RX_DEFINES_SVH
`define ISO_RX_DEFINES_SVH

// ======================================================================
// Register byte offsets; each context repeats its pointer, match and control registers one stride on, the mask pair is shared.
`define IRX_PTR_BASE 16'h040C
`define IRX_MATCH_BASE 16'h410C
`define IRX_CTRL_BASE 16'h0400
`define IRX_CTX_STRIDE 16'h0020
`define IRX_MASK_HI 16'h0078
`define IRX_MASK_LO 16'h007C

// ======================================================================
// Match register fields.
`define IRX_ACCEPT_LABEL_ZERO 28
`define IRX_ACCEPT_LABEL_ONE 29
`define IRX_CYC_HI 24
`define IRX_CYC_LO 12
`define IRX_SYNC_HI 11
`define IRX_SYNC_LO 8
`define IRX_T1F 6
`define IRX_CH_HI 5
`define IRX_CH_LO 0
`define IRX_MATCH_WMASK 32'hF1FF_FF7F

// ======================================================================
// Context control fields.
`define IRX_CTL_SOC 29
`define IRX_CTL_MULTI 28
`define IRX_CTL_RUN 15
`define IRX_CTL_ACTIVE 10

// ======================================================================
// Codes and reset values.
`define IRX_WAIT_SYNC 2'h3
`define IRX_TAG_ONE 2'h1
`define IRX_RST_WORD 32'h0000_0000
`define IRX_RST_MASK 64'h0000_0000_0000_0000

`endif

//--- src/iso_rx_pkg.sv
// Types shared by the receive context match block.
package iso_rx_pkg;
	typedef logic [15:0] apb_addr_t;
	typedef logic [5:0] chan_t;
	typedef logic [1:0] tag_t;
	typedef logic [3:0] sync_t;
	typedef logic [12:0] cycle_t;
	typedef enum logic [1:0] {CTX_IDLE, CTX_WAIT_CYCLE, CTX_ACTIVE} ctx_state_e;
endpackage

//--- src/iso_rx_packet_filter.sv
// Packet filter of one receive context: channel, tag and sync checks.
`timescale 1ns/100ps
`include "iso_rx_defines.svh"

module iso_rx_packet_filter (
	input wire logic [31:0] i_match,
	input wire logic i_multi,
	input wire logic [63:0] i_chmask,
	input wire logic [1:0] i_wait_sel,
	input wire iso_rx_pkg::chan_t i_chan,
	input wire iso_rx_pkg::tag_t i_tag,
	input wire iso_rx_pkg::sync_t i_sync,
	output logic o_hit
);
	import iso_rx_pkg::*;

	logic chan_ok;
	logic tag_ok;
	logic sync_ok;

	// ======================================================================
	// Filter terms.
	// Multi-channel mode trusts the shared mask and ignores the select field.
	always_comb begin
		if (i_multi) begin
			chan_ok = i_chmask[i_chan]; // RULE_12
		end else begin
			chan_ok = (i_chan == i_match[`IRX_CH_HI:`IRX_CH_LO]); // RULE_11
		end
		tag_ok = i_match[`IRX_ACCEPT_LABEL_ZERO + int'(i_tag)]; // RULE_03 RULE_04 RULE_09 RULE_10
		if (i_tag == `IRX_TAG_ONE && i_match[`IRX_T1F] && i_match[`IRX_ACCEPT_LABEL_ONE]) begin
			tag_ok = (i_sync[3:2] == 2'h0); // RULE_08
		end
		// Other tags keep their plain accept bit even with the filter on.
		sync_ok = (i_wait_sel != `IRX_WAIT_SYNC) || (i_sync == i_match[`IRX_SYNC_HI:`IRX_SYNC_LO]); // RULE_07
		o_hit = chan_ok && tag_ok && sync_ok;
	end
endmodule

//--- src/iso_rx_context_match.sv
// Receive context start pointer, match register, start control and APB slave.
`timescale 1ns/100ps
`include "iso_rx_defines.svh"

// Behaviour
// RULE_01: read-only start pointer fetched when run set
// RULE_02: registers repeat per context, 32-byte stride
// RULE_03: tag 11b and 10b gated by bits 31, 30
// RULE_04: tag 01b and 00b gated by bits 29, 28
// RULE_05: start-on-cycle waits for cycle count match
// RULE_06: start-on-cycle enable clears once context active
// RULE_07: wait select 11b compares sync pattern
// RULE_08: label-one filter needs sync upper bits 00b
// RULE_09: other tags unaffected by label-one filter
// RULE_10: filter clear means tag bits alone decide
// RULE_11: single channel from select field bits 5-0
// RULE_12: multi-channel mode uses channel mask registers
// RULE_13: reserved match bits read as zero
// RULE_14: accept only when all conditions hold together
module iso_rx_context_match #(
	parameter int NUM_CTX = 4
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire iso_rx_pkg::apb_addr_t I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [3:0] I_PSTRB,
	input wire logic [NUM_CTX-1:0] I_PTR_LOAD,
	input wire logic [31:0] I_PTR_VALUE,
	input wire logic [2*NUM_CTX-1:0] I_WAIT_SELECT,
	input wire logic I_CYCLE_START,
	input wire iso_rx_pkg::cycle_t I_BUS_CYCLE_COUNT,
	input wire logic I_PKT_VALID,
	input wire iso_rx_pkg::chan_t I_PKT_CHANNEL,
	input wire iso_rx_pkg::tag_t I_PKT_TAG,
	input wire iso_rx_pkg::sync_t I_PKT_SYNC,
	output logic O_PREADY,
	output logic [31:0] O_PRDATA,
	output logic O_PSLVERR,
	output logic [NUM_CTX-1:0] O_PKT_ACCEPT,
	output logic [NUM_CTX-1:0] O_FETCH_REQ,
	output logic [31:0] O_FETCH_ADDR,
	output logic [NUM_CTX-1:0] O_CTX_ACTIVE
);
	import iso_rx_pkg::*;

	// ======================================================================
	// Elaboration check: the context index must fit the stride decode.
	generate
		if (NUM_CTX < 1 || NUM_CTX > 32) begin : g_bad_ctx
			$error("NUM_CTX must lie between 1 and 32");
		end
	endgenerate

	typedef struct packed {
		logic [NUM_CTX-1:0][31:0] ptr;
		logic [NUM_CTX-1:0][31:0] match;
		logic [NUM_CTX-1:0] run;
		logic [NUM_CTX-1:0] soc_en;
		logic [NUM_CTX-1:0] multi;
		ctx_state_e [NUM_CTX-1:0] st;
		logic [63:0] chmask;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic [NUM_CTX-1:0] accept;
		logic [NUM_CTX-1:0] fetch_req;
		logic [31:0] fetch_addr;
		logic [NUM_CTX-1:0] active;
	} state_s;

	state_s s_reg;
	state_s s_next;
	logic [NUM_CTX-1:0] hit;
	logic wr_take;
	logic rd_setup;

	// ======================================================================
	// Per-context address decode and byte-lane merge; the merge serves every writable register bank, the mask pair is decoded directly.
	function automatic logic ctx_at(input apb_addr_t a, input apb_addr_t base, input int n);
		ctx_at = (a == base + 16'(n * 32'(`IRX_CTX_STRIDE))); // RULE_02
	endfunction

	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = wd[8*b +: 8];
			end
		end
		lane_merge = r;
	endfunction

	function automatic logic [31:0] ctrl_word(input logic soc, input logic mul, input logic run,
		input logic act);
		logic [31:0] r;
		r = `IRX_RST_WORD;
		r[`IRX_CTL_SOC] = soc;
		r[`IRX_CTL_MULTI] = mul;
		r[`IRX_CTL_RUN] = run;
		r[`IRX_CTL_ACTIVE] = act;
		ctrl_word = r;
	endfunction

	// ======================================================================
	// One filter per context; all look at the same incoming packet.
	generate
		for (genvar g = 0; g < NUM_CTX; g++) begin : g_filt
			iso_rx_packet_filter u_filt (
				.i_match(s_reg.match[g]),
				.i_multi(s_reg.multi[g]),
				.i_chmask(s_reg.chmask),
				.i_wait_sel(I_WAIT_SELECT[2*g +: 2]),
				.i_chan(I_PKT_CHANNEL),
				.i_tag(I_PKT_TAG),
				.i_sync(I_PKT_SYNC),
				.o_hit(hit[g])
			);
		end
	endgenerate

	// Writes land only at the edge where the master sees pready high.
	assign wr_take = I_PSEL && I_PENABLE && s_reg.pready && I_PWRITE;
	// Read data is prepared during the first access cycle, giving one wait state.
	assign rd_setup = I_PSEL && I_PENABLE && !s_reg.pready;

	// ======================================================================
	// Next-state logic: bus slave, register writes and context sequencing.
	always_comb begin
		logic [31:0] rd;
		logic mapped;
		logic [31:0] cw;
		rd = `IRX_RST_WORD;
		mapped = 1'b0;
		cw = `IRX_RST_WORD;
		s_next = s_reg;
		s_next.accept = '0;
		s_next.fetch_req = '0;
		s_next.pready = rd_setup;
		s_next.pslverr = 1'b0;

		// Read mux and decode; unmapped addresses answer with an error and zero data.
		if (I_PADDR == `IRX_MASK_HI) begin
			rd = s_reg.chmask[63:32];
			mapped = 1'b1;
		end
		if (I_PADDR == `IRX_MASK_LO) begin
			rd = s_reg.chmask[31:0];
			mapped = 1'b1;
		end
		for (int i = 0; i < NUM_CTX; i++) begin
			if (ctx_at(I_PADDR, `IRX_PTR_BASE, i)) begin
				rd = s_reg.ptr[i];
				mapped = 1'b1;
			end
			if (ctx_at(I_PADDR, `IRX_MATCH_BASE, i)) begin
				rd = s_reg.match[i] & `IRX_MATCH_WMASK; // RULE_13
				mapped = 1'b1;
			end
			if (ctx_at(I_PADDR, `IRX_CTRL_BASE, i)) begin
				rd = ctrl_word(s_reg.soc_en[i], s_reg.multi[i], s_reg.run[i], s_reg.st[i] == CTX_ACTIVE);
				mapped = 1'b1;
			end
		end
		if (rd_setup) begin
			s_next.prdata = I_PWRITE ? `IRX_RST_WORD : rd;
			s_next.pslverr = !mapped;
		end

		// Register writes; the pointer is read-only and silently ignores writes.
		if (wr_take && I_PADDR == `IRX_MASK_HI) begin
			s_next.chmask[63:32] = lane_merge(s_reg.chmask[63:32], I_PWDATA, I_PSTRB);
		end
		if (wr_take && I_PADDR == `IRX_MASK_LO) begin
			s_next.chmask[31:0] = lane_merge(s_reg.chmask[31:0], I_PWDATA, I_PSTRB);
		end
		for (int i = 0; i < NUM_CTX; i++) begin
			if (wr_take && ctx_at(I_PADDR, `IRX_MATCH_BASE, i)) begin
				s_next.match[i] = lane_merge(s_reg.match[i], I_PWDATA, I_PSTRB) & `IRX_MATCH_WMASK; // RULE_13
			end
			if (wr_take && ctx_at(I_PADDR, `IRX_CTRL_BASE, i)) begin
				cw = lane_merge(ctrl_word(s_reg.soc_en[i], s_reg.multi[i], s_reg.run[i], 1'b0),
					I_PWDATA, I_PSTRB);
				s_next.soc_en[i] = cw[`IRX_CTL_SOC];
				s_next.multi[i] = cw[`IRX_CTL_MULTI];
				s_next.run[i] = cw[`IRX_CTL_RUN];
			end
			// The descriptor engine owns the pointer value. RULE_01
			if (I_PTR_LOAD[i]) begin
				s_next.ptr[i] = I_PTR_VALUE;
			end
		end

		// Context sequencing; only one context can see run rise per cycle, so one fetch address suffices.
		for (int i = 0; i < NUM_CTX; i++) begin
			case (s_reg.st[i])
				CTX_IDLE: begin
					if (s_reg.run[i]) begin
						s_next.fetch_req[i] = 1'b1; // RULE_01
						s_next.fetch_addr = s_reg.ptr[i]; // RULE_01
						if (s_reg.soc_en[i]) begin
							s_next.st[i] = CTX_WAIT_CYCLE; // RULE_05
						end else begin
							s_next.st[i] = CTX_ACTIVE;
						end
					end
				end
				CTX_WAIT_CYCLE: begin
					if (!s_reg.run[i]) begin
						s_next.st[i] = CTX_IDLE;
					end else if (I_CYCLE_START &&
						I_BUS_CYCLE_COUNT == s_reg.match[i][`IRX_CYC_HI:`IRX_CYC_LO]) begin
						s_next.st[i] = CTX_ACTIVE; // RULE_05
						s_next.soc_en[i] = 1'b0; // RULE_06
					end
				end
				CTX_ACTIVE: begin
					if (!s_reg.run[i]) begin
						s_next.st[i] = CTX_IDLE;
					end else begin
						s_next.accept[i] = I_PKT_VALID && hit[i]; // RULE_14
					end
				end
				default: begin
					s_next.st[i] = CTX_IDLE;
				end
			endcase
			// The active flag is registered so the output never depends on a state decode.
			s_next.active[i] = (s_next.st[i] == CTX_ACTIVE);
		end
	end

	// ======================================================================
	// State register with synchronous reset.
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			s_reg.ptr <= '0;
			s_reg.match <= '0;
			s_reg.run <= '0;
			s_reg.soc_en <= '0;
			s_reg.multi <= '0;
			for (int i = 0; i < NUM_CTX; i++) begin
				s_reg.st[i] <= CTX_IDLE;
			end
			s_reg.active <= '0;
			s_reg.chmask <= `IRX_RST_MASK;
			s_reg.pready <= 1'b0;
			s_reg.prdata <= `IRX_RST_WORD;
			s_reg.pslverr <= 1'b0;
			s_reg.accept <= '0;
			s_reg.fetch_req <= '0;
			s_reg.fetch_addr <= `IRX_RST_WORD;
		end else begin
			s_reg <= s_next;
		end
	end

	// Every output comes straight from the state register.
	always_comb begin
		O_PREADY = s_reg.pready;
		O_PRDATA = s_reg.prdata;
		O_PSLVERR = s_reg.pslverr;
		O_PKT_ACCEPT = s_reg.accept;
		O_FETCH_REQ = s_reg.fetch_req;
		O_FETCH_ADDR = s_reg.fetch_addr;
		O_CTX_ACTIVE = s_reg.active;
	end

	// ======================================================================
	// Checks beside the logic they guard.
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);

	sequence s_access;
		I_PSEL && I_PENABLE && !O_PREADY;
	endsequence

	a_apb_ready_once: assert property (s_access |=> O_PREADY ##1 !O_PREADY)
		else $error("pready did not pulse once after access");

	generate
		for (genvar g = 0; g < NUM_CTX; g++) begin : g_chk
			sequence s_run_seen;
				s_reg.st[g] == CTX_IDLE && s_reg.run[g];
			endsequence
			sequence s_cycle_hit;
				s_reg.st[g] == CTX_WAIT_CYCLE && s_reg.run[g] && I_CYCLE_START &&
					I_BUS_CYCLE_COUNT == s_reg.match[g][`IRX_CYC_HI:`IRX_CYC_LO];
			endsequence

			a_fetch_on_run: assert property (s_run_seen |=> O_FETCH_REQ[g] && // RULE_01
				O_FETCH_ADDR == $past(s_reg.ptr[g]))
				else $error("run did not fetch from the start pointer");
			a_ctx_read_stride: assert property (s_access ##0 (!I_PWRITE && // RULE_02
				I_PADDR == `IRX_MATCH_BASE + 16'(g * 32)) |=> O_PRDATA == $past(s_reg.match[g]))
				else $error("match read did not return its own context");
			a_cycle_start: assert property (s_cycle_hit |=> O_CTX_ACTIVE[g] && !s_reg.soc_en[g]) // RULE_05 RULE_06
				else $error("cycle match did not activate and clear enable");
			a_wait_blocks: assert property (s_reg.st[g] == CTX_WAIT_CYCLE && !I_CYCLE_START // RULE_05
				|=> !O_CTX_ACTIVE[g])
				else $error("context active before cycle match");
			a_accept_active: assert property (O_PKT_ACCEPT[g] |-> $past(O_CTX_ACTIVE[g]) && // RULE_14
				$past(I_PKT_VALID))
				else $error("packet accepted while inactive");
			a_tag_bit_set: assert property (O_PKT_ACCEPT[g] |-> // RULE_03 RULE_04
				$past(s_reg.match[g][`IRX_ACCEPT_LABEL_ZERO + int'(I_PKT_TAG)]))
				else $error("packet accepted with its tag disabled");
			a_label_one_sync: assert property (O_PKT_ACCEPT[g] && $past(I_PKT_TAG == `IRX_TAG_ONE && // RULE_08
				s_reg.match[g][`IRX_T1F]) |-> $past(I_PKT_SYNC[3:2]) == 2'h0)
				else $error("label-one filter let a bad sync through");
			a_tag_plain: assert property ($past(O_CTX_ACTIVE[g]) && s_reg.run[g] && // RULE_09 RULE_10
				$past(I_PKT_VALID && s_reg.run[g] && !s_reg.multi[g] &&
				I_PKT_TAG != `IRX_TAG_ONE && I_WAIT_SELECT[2*g +: 2] != `IRX_WAIT_SYNC &&
				I_PKT_CHANNEL == s_reg.match[g][`IRX_CH_HI:`IRX_CH_LO] &&
				s_reg.match[g][`IRX_ACCEPT_LABEL_ZERO + int'(I_PKT_TAG)]) |-> O_PKT_ACCEPT[g])
				else $error("plainly matching packet was dropped");
			a_sync_wait: assert property (O_PKT_ACCEPT[g] && $past(I_WAIT_SELECT[2*g +: 2]) == `IRX_WAIT_SYNC |-> // RULE_07
				$past(I_PKT_SYNC) == $past(s_reg.match[g][`IRX_SYNC_HI:`IRX_SYNC_LO]))
				else $error("sync wait accepted a wrong pattern");
			a_chan_single: assert property (O_PKT_ACCEPT[g] && !$past(s_reg.multi[g]) |-> // RULE_11
				$past(I_PKT_CHANNEL) == $past(s_reg.match[g][`IRX_CH_HI:`IRX_CH_LO]))
				else $error("packet accepted on another channel");
			a_chan_multi: assert property (O_PKT_ACCEPT[g] && $past(s_reg.multi[g]) |-> // RULE_12
				$past(s_reg.chmask[I_PKT_CHANNEL]))
				else $error("multi-channel accept outside the mask");
			a_reserved_zero: assert property (s_reg.match[g][27:25] == 3'h0 && // RULE_13
				s_reg.match[g][7] == 1'b0)
				else $error("reserved match bits not zero");
		end
	endgenerate
endmodule

//--- verif/iso_link_model.sv
// Link layer model that presents isochronous packet headers and cycle-start counts.
`timescale 1ns/100ps

module iso_link_model (
	input wire logic i_clk,
	output logic o_pkt_valid,
	output iso_rx_pkg::chan_t o_chan,
	output iso_rx_pkg::tag_t o_tag,
	output iso_rx_pkg::sync_t o_sync,
	output logic o_cyc_start,
	output iso_rx_pkg::cycle_t o_cyc_count
);
	import iso_rx_pkg::*;

	// ==========================================================
	// Strobes start low; idle fields hold the inverse of the last header so stale data never looks valid.
	initial begin
		o_pkt_valid = 1'b0;
		o_cyc_start = 1'b0;
		o_chan = 6'h3F;
		o_tag = 2'h3;
		o_sync = 4'hF;
		o_cyc_count = 13'h1FFF;
	end

	// ==========================================================
	// One header for one cycle, then the fields are scrambled.
	task send(input chan_t ch, input tag_t tg, input sync_t sy);
		@(posedge i_clk);
		o_pkt_valid <= 1'b1;
		o_chan <= ch;
		o_tag <= tg;
		o_sync <= sy;
		@(posedge i_clk);
		o_pkt_valid <= 1'b0;
		o_chan <= ~ch;
		o_tag <= ~tg;
		o_sync <= ~sy;
	endtask

	// One cycle-start pulse carrying the bus cycle count.
	task cycle(input cycle_t cnt);
		@(posedge i_clk);
		o_cyc_start <= 1'b1;
		o_cyc_count <= cnt;
		@(posedge i_clk);
		o_cyc_start <= 1'b0;
		o_cyc_count <= ~cnt;
	endtask
endmodule

//--- verif/tb_top.sv
// Self-checking testbench of the receive context match block.
`timescale 1ns/100ps
`include "iso_rx_defines.svh"

module tb_top;
	import iso_rx_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	apb_addr_t paddr = '0;
	logic [31:0] pwdata = '0;
	logic [1:0] ptr_load = '0;
	logic [31:0] ptr_value = '0;
	logic [3:0] wait_sel = '0;
	logic pv, cs, rdy, err, v_prev = 1'b0;
	chan_t pch;
	tag_t ptg;
	sync_t psy;
	cycle_t pcc;
	logic [31:0] prdata, faddr, rnd = 32'hF8F4BF26, m;
	logic [1:0] acc, freq, act, ws;
	logic [32:0] exp_apb[$];
	logic [1:0] exp_acc[$];
	int err_total = 0;
	int num_checks = 0;

	iso_rx_context_match #(.NUM_CTX(2)) iso_rx_context_match_i (.I_CLK_SYS(clk), .I_RST_N(rst_n),
		.I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.I_PSTRB(4'hF), .I_PTR_LOAD(ptr_load), .I_PTR_VALUE(ptr_value), .I_WAIT_SELECT(wait_sel),
		.I_CYCLE_START(cs), .I_BUS_CYCLE_COUNT(pcc), .I_PKT_VALID(pv), .I_PKT_CHANNEL(pch), .I_PKT_TAG(ptg),
		.I_PKT_SYNC(psy), .O_PREADY(rdy), .O_PRDATA(prdata), .O_PSLVERR(err), .O_PKT_ACCEPT(acc),
		.O_FETCH_REQ(freq), .O_FETCH_ADDR(faddr), .O_CTX_ACTIVE(act));
	iso_link_model iso_link_model_i (.i_clk(clk), .o_pkt_valid(pv), .o_chan(pch), .o_tag(ptg),
		.o_sync(psy), .o_cyc_start(cs), .o_cyc_count(pcc));

	// ==========================================================
	// Clock of 8 ns period.
	always #4 clk = ~clk;

	task chk(input logic [32:0] s, input logic [32:0] e);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task complete_run;
		$display("checks=%0d mismatches=%0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Expected single-channel verdict of an active context.
	function logic hit(input logic [31:0] mr, input logic [1:0] ws, input chan_t ch, input tag_t tg, input sync_t sy);
		logic ok;
		ok = (ch == mr[5:0]) && mr[28 + tg];
		if (tg == 2'h1 && mr[6] && sy[3:2] != 2'h0) begin
			ok = 1'b0;
		end
		if (ws == 2'h3 && sy != mr[11:8]) begin
			ok = 1'b0;
		end
		return ok;
	endfunction

	// ==========================================================
	// Monitor: every answer takes the oldest note off its queue.
	always @(posedge clk) begin
		if (psel && penable && rdy) begin
			chk({err, prdata}, exp_apb.pop_front());
		end
		if (v_prev) begin
			chk({31'h0, acc}, {31'h0, exp_acc.pop_front()});
		end
		v_prev = pv;
	end

	// One APB transfer; the expected {error, data} is noted first.
	task apb(input logic w, input apb_addr_t a, input logic [31:0] d, input logic [32:0] e);
		int n;
		exp_apb.push_back(e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (rdy === 1'b1) break;
		end
		if (n == 20) begin
			err_total++;
			complete_run();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input apb_addr_t a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask

	task rd(input apb_addr_t a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, e});
	endtask

	task wait_fetch(input int c);
		int n;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (freq[c] === 1'b1) break;
		end
		if (n == 20) begin
			err_total++;
			complete_run();
		end
	endtask

	task pkt(input chan_t ch, input tag_t tg, input sync_t sy, input logic [1:0] e);
		exp_acc.push_back(e);
		iso_link_model_i.send(ch, tg, sy);
	endtask

	// ==========================================================
	// Main sequence.
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd(`IRX_MATCH_BASE, 32'h0);
		rd(`IRX_CTRL_BASE, 32'h0);
		apb(1'b0, 16'h0100, 32'h0, 33'h1_0000_0000);
		$display("test reset_and_map done");
		wr(`IRX_MATCH_BASE, 32'hFFFF_FFFF);
		rd(`IRX_MATCH_BASE, `IRX_MATCH_WMASK);
		rnd = lfsr(rnd);
		wr(`IRX_MATCH_BASE + `IRX_CTX_STRIDE, rnd);
		rd(`IRX_MATCH_BASE + `IRX_CTX_STRIDE, rnd & `IRX_MATCH_WMASK);
		rd(`IRX_MATCH_BASE, `IRX_MATCH_WMASK);
		$display("test match_register done");
		@(posedge clk);
		ptr_load <= 2'b01;
		ptr_value <= rnd;
		@(posedge clk);
		ptr_load <= 2'b00;
		ptr_value <= ~rnd;
		wr(`IRX_PTR_BASE, ~rnd);
		rd(`IRX_PTR_BASE, rnd);
		wr(`IRX_CTRL_BASE, 32'h0000_8000);
		wait_fetch(0);
		chk({1'b0, faddr}, {1'b0, rnd});
		@(posedge clk);
		chk({32'h0, act[0]}, 33'h1);
		$display("test start_fetch done");
		// Random match words, wait selects and headers; every tag value appears.
		for (int k = 0; k < 64; k++) begin
			rnd = lfsr(rnd);
			m = rnd;
			wr(`IRX_MATCH_BASE, m);
			// The expectation uses the new select itself, not the not-yet-updated port variable.
			ws = rnd[14:13];
			wait_sel <= {2'b00, ws};
			rnd = lfsr(rnd);
			pkt(k[2] ? m[5:0] : m[5:0] ^ 6'h01, k[1:0], rnd[3:0],
				{1'b0, hit(m, ws, k[2] ? m[5:0] : m[5:0] ^ 6'h01, k[1:0], rnd[3:0])});
		end
		wait_sel <= 4'h0;
		$display("test packet_filter done");
		wr(`IRX_CTRL_BASE, 32'h0);
		wr(`IRX_MASK_HI, 32'h0000_0002);
		wr(`IRX_MASK_LO, 32'h0);
		wr(`IRX_MATCH_BASE, 32'hF000_0002);
		wr(`IRX_CTRL_BASE, 32'h1000_8000);
		wait_fetch(0);
		pkt(6'd33, 2'h0, 4'h0, 2'b01);
		pkt(6'd2, 2'h0, 4'h0, 2'b00);
		wr(`IRX_CTRL_BASE, 32'h0);
		$display("test multi_channel done");
		wr(`IRX_MATCH_BASE + `IRX_CTX_STRIDE, 32'hF000_0005 | (32'h1ABC << 12));
		wr(`IRX_CTRL_BASE + `IRX_CTX_STRIDE, 32'h2000_8000);
		wait_fetch(1);
		pkt(6'd5, 2'h0, 4'h0, 2'b00);
		iso_link_model_i.cycle(13'h1ABB);
		repeat (2) @(posedge clk);
		chk({32'h0, act[1]}, 33'h0);
		iso_link_model_i.cycle(13'h1ABC);
		repeat (2) @(posedge clk);
		chk({32'h0, act[1]}, 33'h1);
		rd(`IRX_CTRL_BASE + `IRX_CTX_STRIDE, 32'h0000_8400);
		pkt(6'd5, 2'h3, 4'h0, 2'b10);
		$display("test start_on_cycle done");
		repeat (4) @(posedge clk);
		complete_run();
	end
endmodule
